// file: ssr_receiver_port.sv
// How it works
// [RL1] One-sync mode: match checked every bit, first match locks alignment.
// [RL2] Two-sync mode: next character must match too, else hunt again.
// [RL3] Sync codes seen before lock never enter the receive queue.
// [RL4] With strip set, every character equal to the sync code is dropped.
// [RL5] Lock holds until clear-sync, receiver reset or lost carrier; while set no hunt takes place.
// [RL6] Locked characters enter the queue and advance on each enable pulse that is not a queue read.
// [RL7] Data-available: last slot full, or last two full in two-byte mode.
// [RL8] Receive interrupt enable lets data-available pull the request low.
// [RL9] Queue read clears data-available; later pulses bring the next one.
// [RL10] Host leaves one enable pulse between the two reads of two-byte mode.
// [RL11] Parity error travels with its character; may interrupt via error enable.
// [RL12] Host checks parity status before reading the second byte.
// [RL13] Character into occupied input slot overwrites and sets overrun.
// [RL14] Overrun clears by status read showing it, then queue read, or by receiver reset.
// [RL15] Carrier-detect rise latches status; status then queue read clears it.
// [RL16] After clearing, carrier-detect status follows the input.
// [RL17] Data lines driven only during a selected read with enable high.
// [RL18] Read/write picks direction and read-only versus write-only registers.
// [RL19] Select low: status/control 1; high: queue or address-control target.
// [RL20] Status interrupt bit mirrors the request; clears when sources clear.
// [RL21] Reset bits hold sections; writing them clears their flags.
// [RL22] Control 3 bits 3 and 2 clear underflow and clear-to-send latches.
// [RL23] Control 3 bit 1 picks one or two sync codes; bit 0 external sync.
// [RL24] Serial data is sampled on the rising receive clock edge.
// [RL25] Characters cross into the system clock by a toggle handshake.
`timescale 1ns/1ps
`include "ssr_cfg.svh"
module ssr_receiver_port
	import ssr_pkg::*;
(
	input  wire logic       mclk,             // System clock.
	input  wire logic       rst_b,            // Reset, active low.
	input  wire logic       e_pin,            // Bus enable strobe.
	input  wire logic       cs_n,             // Chip select, active low.
	input  wire logic       reg_select,       // Register select.
	input  wire logic       rw,               // High for read.
	input  wire logic [7:0] d_in,             // Data bus in.
	output logic      [7:0] d_out,            // Data bus out.
	output logic            d_oe,             // Data bus drive.
	output logic            irq_out,          // Request level, always low.
	output logic            irq_oe,           // Request pulled low when high.
	input  wire logic       carrier_detect_n, // Carrier detect pin.
	input  wire logic       cts_n,            // Clear-to-send pin.
	input  wire logic       tx_underflow,     // Underflow pulse from transmitter.
	input  wire logic       tx_fifo_free,     // Transmit queue has room.
	output logic      [7:0] tx_wr_data,       // Byte for the transmit queue.
	output logic            tx_wr_stb,        // Transmit queue write.
	output logic            tx_reset_bit,     // Transmitter held in reset.
	input  wire logic       rx_clk,           // Receive clock.
	input  wire logic       rx_data           // Serial data.
);

// ----------------------------------------
// System clock side
// ----------------------------------------
logic        rst_s1_r, rst_s2_r;
logic [15:0] pin_s1_r, pin_s2_r;
logic [3:0]  edge_r;
logic [7:0]  c1_r, c2_r, sync_r, d_out_r, tx_data_r;
logic [1:0]  c3_r;
logic        tg_s1_r, tg_s2_r, tg_s3_r;
logic [2:0]  v_r, pe_r;
logic [7:0]  dat_r [3];
logic        ovr_r, ovr_arm_r, dcd_r, dcd_arm_r, cts_r, tuf_r;
logic        d_oe_r, irq_oe_r, tx_stb_r;
logic        rx_tgl_r, rx_pe_r;
logic [7:0]  rx_chr_r;

wire       e_s    = pin_s2_r[15];
wire       cs_s   = pin_s2_r[14];
wire       rs_s   = pin_s2_r[13];
wire       rw_s   = pin_s2_r[12];
wire [7:0] d_s    = pin_s2_r[11:4];
wire       cd_s   = pin_s2_r[3];
wire       ctsp_s = pin_s2_r[2];
wire       tufp_s = pin_s2_r[1];
wire       free_s = pin_s2_r[0];
wire       ep     = e_s & ~edge_r[3];
wire       cd_up  = cd_s & ~edge_r[2];
wire       cts_up = ctsp_s & ~edge_r[1];
wire       tuf_up = tufp_s & ~edge_r[0];

// [RL18] Direction and select decode.
wire       sel     = ep & ~cs_s;
wire       rd_stat = sel & rw_s & ~rs_s;
wire       rd_fifo = sel & rw_s & rs_s;
wire       wr_c1   = sel & ~rw_s & ~rs_s;
wire       wr_hi   = sel & ~rw_s & rs_s;
wire [1:0] ac      = c1_r[`SSR_C1_ACLO +: 2];
// [RL19] Address-control steers writes.
wire       wr_c2   = wr_hi & (ac == `SSR_AC_C2);
wire       wr_c3   = wr_hi & (ac == `SSR_AC_C3);
wire       wr_sync = wr_hi & (ac == `SSR_AC_SYNC);
wire       wr_tx   = wr_hi & (ac == `SSR_AC_TX);
// [RL21] Writing a one to a reset bit.
wire       rx_rst_wr = wr_c1 & d_s[`SSR_C1_RXRST];
wire       tx_rst_wr = wr_c1 & d_s[`SSR_C1_TXRST];
// [RL22] Control 3 clear strobes.
wire       clr_cts = wr_c3 & d_s[`SSR_C3_CLRCTS];
wire       clr_tuf = wr_c3 & d_s[`SSR_C3_CLRTUF];

// [RL25] Toggle from the receive side marks a new character.
wire       chr_new = tg_s2_r ^ tg_s3_r;
// [RL6] On an enable pulse without a queue read, an entry moves when the next slot is free or moving on.
wire [1:0] mv;
assign mv[1] = ep & ~rd_fifo & v_r[1] & ~v_r[2];
assign mv[0] = ep & ~rd_fifo & v_r[0] & (~v_r[1] | mv[1]);
wire [2:0]  take = {mv[1], mv[0], chr_new};
wire [2:0]  leave = {rd_fifo, mv[1], mv[0]};
wire [23:0] in_d = {dat_r[1], dat_r[0], rx_chr_r};
wire [2:0]  in_p = {pe_r[1], pe_r[0], rx_pe_r};

// [RL7] Data-available by transfer mode.
wire rx_data_avail = c2_r[`SSR_C2_BYTE1] ? v_r[2] : (v_r[2] & v_r[1]);
// [RL11] Parity status of the character at the output.
wire stat_pe = v_r[2] & pe_r[2];
// [RL13] Input slot still occupied.
wire ovr_set = chr_new & v_r[0] & ~mv[0];
wire slot_free = free_s & ~c1_r[`SSR_C1_TXRST] & ~(ctsp_s & ~c3_r[`SSR_C3_EXT]);
// [RL16] Status follows the pin once the latch is clear.
wire dcd_bit = dcd_r | cd_s;
wire [7:0] status = {irq_oe_r, stat_pe, ovr_r, tuf_r, cts_r | ctsp_s,
	dcd_bit, slot_free, rx_data_avail};
// [RL8] [RL20] Interrupt sources gated by their enables.
wire irq_src = (c1_r[`SSR_C1_RIE] & rx_data_avail) | (c1_r[`SSR_C1_TIE] & slot_free)
	| (c2_r[`SSR_C2_EIE] & (stat_pe | ovr_r | tuf_r | cts_r | dcd_r));

// [RL14] Status read showing the flag arms the queue-read clear.
wire ovr_nxt = ovr_set | (ovr_r & ~(rd_fifo & ovr_arm_r) & ~rx_rst_wr);
wire ovr_arm_nxt = (rd_stat & ovr_r) | (ovr_arm_r & ~rd_fifo);
// [RL15] Carrier-detect latch with the same two-step clear.
wire dcd_nxt = cd_up | (dcd_r & ~(rd_fifo & dcd_arm_r) & ~rx_rst_wr);
wire dcd_arm_nxt = (rd_stat & dcd_bit) | (dcd_arm_r & ~rd_fifo);
wire cts_nxt = cts_up | (cts_r & ~clr_cts & ~tx_rst_wr);
wire tuf_nxt = tuf_up | (tuf_r & ~clr_tuf & ~tx_rst_wr);
// [RL17] Drive only for a selected read while enable is high.
wire d_oe_nxt = e_s & ~cs_s & rw_s;
wire [7:0] d_out_nxt = rd_stat ? status : (rd_fifo ? dat_r[2] : d_out_r);

always_ff @(posedge mclk or negedge rst_b)
begin
	if (!rst_b)
	begin
		rst_s1_r <= 1'b0;
		rst_s2_r <= 1'b0;
	end
	else
	begin
		rst_s1_r <= 1'b1;
		rst_s2_r <= rst_s1_r;
	end
end

always_ff @(posedge mclk or negedge rst_s2_r)
begin
	if (!rst_s2_r)
	begin
		pin_s1_r <= 16'h0000;
		pin_s2_r <= 16'h0000;
		edge_r   <= 4'h0;
		tg_s1_r  <= 1'b0;
		tg_s2_r  <= 1'b0;
		tg_s3_r  <= 1'b0;
	end
	else
	begin
		pin_s1_r <= {e_pin, cs_n, reg_select, rw, d_in, carrier_detect_n,
			cts_n, tx_underflow, tx_fifo_free};
		pin_s2_r <= pin_s1_r;
		edge_r   <= {e_s, cd_s, ctsp_s, tufp_s};
		tg_s1_r  <= rx_tgl_r;
		tg_s2_r  <= tg_s1_r;
		tg_s3_r  <= tg_s2_r;
	end
end

always_ff @(posedge mclk or negedge rst_s2_r)
begin
	if (!rst_s2_r)
	begin
		c1_r   <= `SSR_C1_RST;
		c2_r   <= `SSR_C2_RST;
		c3_r   <= `SSR_C3_RST;
		sync_r <= `SSR_SYNC_RST;
	end
	else
	begin
		c1_r   <= wr_c1 ? d_s : c1_r;
		c2_r   <= wr_c2 ? d_s : c2_r;
		c3_r   <= wr_c3 ? d_s[1:0] : c3_r;
		sync_r <= wr_sync ? d_s : sync_r;
	end
end

always_ff @(posedge mclk or negedge rst_s2_r)
begin
	if (!rst_s2_r)
	begin
		ovr_r     <= 1'b0;
		ovr_arm_r <= 1'b0;
		dcd_r     <= 1'b0;
		dcd_arm_r <= 1'b0;
		cts_r     <= 1'b0;
		tuf_r     <= 1'b0;
		d_oe_r    <= 1'b0;
		d_out_r   <= 8'h00;
		irq_oe_r  <= 1'b0;
		tx_stb_r  <= 1'b0;
		tx_data_r <= 8'h00;
	end
	else
	begin
		ovr_r     <= ovr_nxt;
		ovr_arm_r <= ovr_arm_nxt;
		dcd_r     <= dcd_nxt;
		dcd_arm_r <= dcd_arm_nxt;
		cts_r     <= cts_nxt;
		tuf_r     <= tuf_nxt;
		d_oe_r    <= d_oe_nxt;
		d_out_r   <= d_out_nxt;
		irq_oe_r  <= irq_src;
		tx_stb_r  <= wr_tx;
		tx_data_r <= wr_tx ? d_s : tx_data_r;
	end
end

// [RL9] Read empties the last slot; shifts follow on later pulses.
genvar gi;
generate
	for (gi = 0; gi < 3; gi++)
	begin : g_slot
		always_ff @(posedge mclk or negedge rst_s2_r)
		begin
			if (!rst_s2_r)
			begin
				v_r[gi]   <= 1'b0;
				pe_r[gi]  <= 1'b0;
				dat_r[gi] <= 8'h00;
			end
			else
			begin
				v_r[gi]   <= take[gi] | (v_r[gi] & ~leave[gi]);
				pe_r[gi]  <= take[gi] ? in_p[gi] : (pe_r[gi] & ~rx_rst_wr);
				dat_r[gi] <= take[gi] ? in_d[gi*8 +: 8] : dat_r[gi];
			end
		end
	end
endgenerate

assign d_out        = d_out_r;
assign d_oe         = d_oe_r;
assign irq_out      = 1'b0;
assign irq_oe       = irq_oe_r;
assign tx_wr_data   = tx_data_r;
assign tx_wr_stb    = tx_stb_r;
assign tx_reset_bit = c1_r[`SSR_C1_TXRST];

// ----------------------------------------
// Receive clock side
// ----------------------------------------
logic        rr_s1_r, rr_s2_r, cdr_s1_r, cdr_s2_r;
logic [15:0] cfg_s1_r, cfg_s2_r;
logic [8:0]  sr_r;
logic [3:0]  cnt_r;
ssr_sync_t   st_r, st_nxt;

wire [7:0] r_sync  = cfg_s2_r[15:8];
wire [2:0] r_wls   = cfg_s2_r[7:5];
// [RL23] Sync mode selection bits.
wire       r_one   = cfg_s2_r[4];
wire       r_ext   = cfg_s2_r[3];
wire       r_strip = cfg_s2_r[1];
// [RL5] Clear-sync, receiver reset or lost carrier hold the hunt.
wire       hold = cfg_s2_r[2] | cfg_s2_r[0] | cdr_s2_r;

wire       par_en = (r_wls != 3'h2) & (r_wls != 3'h3);
wire [3:0] dlen = (r_wls[2:1] == 2'h0) ? 4'h6 :
	((r_wls == 3'h2) | (r_wls[2:1] == 2'h2)) ? 4'h7 : 4'h8;
wire [3:0] tot = dlen + {3'h0, par_en};
// [RL24] Shift in least significant bit first.
wire [8:0] sr_nxt = {rx_data, sr_r[8:1]};
wire [8:0] algn = sr_nxt >> (4'h9 - tot);
wire [7:0] mask = 8'hFF >> (4'h8 - dlen);
wire [7:0] chr = algn[7:0] & mask;
wire       is_sync = chr == (r_sync & mask);
// [RL11] Parity checked against the selected sense.
wire       perr = par_en & (^chr ^ algn[dlen] ^ r_wls[0]);
wire       done = cnt_r == (tot - 4'h1);
// [RL4] Stripped sync codes never hand over.
wire       deliver = ~hold & (st_r == SSR_SYNCED) & done & ~(r_strip & is_sync);

always_comb
begin
	st_nxt = st_r;
	if (hold)
		st_nxt = r_ext ? SSR_SYNCED : SSR_HUNT;
	else
		unique case (st_r)
			// [RL1] One-sync locks on the first bitwise match.
			SSR_HUNT:
				if (is_sync)
					st_nxt = r_one ? SSR_SYNCED : SSR_SECOND;
			// [RL2] Second code must follow directly.
			SSR_SECOND:
				if (done)
					st_nxt = is_sync ? SSR_SYNCED : SSR_HUNT;
			SSR_SYNCED:
				st_nxt = SSR_SYNCED;
			default:
				st_nxt = SSR_HUNT;
		endcase
end

always_ff @(posedge rx_clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		rr_s1_r <= 1'b0;
		rr_s2_r <= 1'b0;
	end
	else
	begin
		rr_s1_r <= 1'b1;
		rr_s2_r <= rr_s1_r;
	end
end

always_ff @(posedge rx_clk or negedge rr_s2_r)
begin
	if (!rr_s2_r)
	begin
		cfg_s1_r <= 16'h0001;
		cfg_s2_r <= 16'h0001;
		cdr_s1_r <= 1'b1;
		cdr_s2_r <= 1'b1;
		sr_r     <= `SSR_SR_RST;
		cnt_r    <= 4'h0;
		st_r     <= SSR_HUNT;
		rx_tgl_r <= 1'b0;
		rx_chr_r <= 8'h00;
		rx_pe_r  <= 1'b0;
	end
	else
	begin
		cfg_s1_r <= {sync_r, c2_r[`SSR_C2_WLSLO +: 3], c3_r[`SSR_C3_ONE],
			c3_r[`SSR_C3_EXT], c1_r[`SSR_C1_CLRSYN], c1_r[`SSR_C1_STRIP],
			c1_r[`SSR_C1_RXRST]};
		cfg_s2_r <= cfg_s1_r;
		cdr_s1_r <= carrier_detect_n;
		cdr_s2_r <= cdr_s1_r;
		sr_r     <= hold ? `SSR_SR_RST : sr_nxt;
		cnt_r    <= (hold | done | (st_r == SSR_HUNT)) ? 4'h0 : cnt_r + 4'h1;
		st_r     <= st_nxt;
		// [RL3] Only locked characters flip the handoff toggle.
		rx_tgl_r <= rx_tgl_r ^ deliver;
		rx_chr_r <= deliver ? chr : rx_chr_r;
		rx_pe_r  <= deliver ? perr : rx_pe_r;
	end
end

// ----------------------------------------
// Checks
// ----------------------------------------
a_rx_hand_synced: assert property (@(posedge rx_clk) disable iff (!rr_s2_r) // RL3
	$changed(rx_tgl_r) |-> $past(st_r) == SSR_SYNCED)
	else $error("character handed over without lock");
a_strip_drop: assert property (@(posedge rx_clk) disable iff (!rr_s2_r) // RL4
	$changed(rx_tgl_r) |-> !($past(r_strip) && $past(is_sync)))
	else $error("stripped sync code handed over");
a_one_sync_lock: assert property (@(posedge rx_clk) disable iff (!rr_s2_r) // RL1
	!hold && st_r == SSR_HUNT && r_one && is_sync |=> st_r == SSR_SYNCED)
	else $error("one-sync match did not lock");
a_two_sync_miss: assert property (@(posedge rx_clk) disable iff (!rr_s2_r) // RL2
	!hold && st_r == SSR_SECOND && done && !is_sync |=> st_r == SSR_HUNT)
	else $error("missed second code did not resume hunt");
a_clear_sync_hunt: assert property (@(posedge rx_clk) disable iff (!rr_s2_r) // RL5
	hold && !r_ext |=> st_r == SSR_HUNT ##0 cnt_r == 4'h0)
	else $error("clear sync did not drop lock");
a_rx_irq_raise: assert property (@(posedge mclk) disable iff (!rst_s2_r) // RL8
	c1_r[`SSR_C1_RIE] && rx_data_avail |=> irq_oe && status[7])
	else $error("data available did not request");
a_fifo_read_pop: assert property (@(posedge mclk) disable iff (!rst_s2_r) // RL9
	rd_fifo && !c2_r[`SSR_C2_BYTE1] |=> !rx_data_avail ##0 d_out == $past(dat_r[2]))
	else $error("queue read did not clear data available");
a_overrun_set: assert property (@(posedge mclk) disable iff (!rst_s2_r) // RL13
	ovr_set |=> ovr_r ##0 v_r[0])
	else $error("overrun not flagged");
a_overrun_seen: assert property (@(posedge mclk) disable iff (!rst_s2_r) // RL14
	$fell(ovr_r) && !$past(rx_rst_wr) |-> $past(ovr_arm_r))
	else $error("overrun cleared without status read");
a_carrier_latch: assert property (@(posedge mclk) disable iff (!rst_s2_r) // RL15
	cd_up |=> dcd_r ##1 d_out_r[`SSR_ST_DCD] || !$past(rd_stat))
	else $error("carrier rise not latched");
a_bus_float: assert property (@(posedge mclk) disable iff (!rst_s2_r) // RL17
	d_oe |-> $past(e_s) && !$past(cs_s) && $past(rw_s))
	else $error("bus driven outside a read");
a_irq_release: assert property (@(posedge mclk) disable iff (!rst_s2_r) // RL20
	!irq_src [*2] |-> !irq_oe)
	else $error("request held with no source");
c_lock: cover property (@(posedge rx_clk) disable iff (!rr_s2_r)
	st_r == SSR_SECOND ##1 st_r == SSR_SYNCED);
c_overrun: cover property (@(posedge mclk) disable iff (!rst_s2_r) ovr_set);
c_two_byte: cover property (@(posedge mclk) disable iff (!rst_s2_r)
	!c2_r[`SSR_C2_BYTE1] && rd_fifo);
c_carrier: cover property (@(posedge mclk) disable iff (!rst_s2_r)
	rd_fifo && dcd_arm_r && dcd_r);

endmodule : ssr_receiver_port

// file: ssr_cfg.svh
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH
// Control 1 fields.
`define SSR_C1_RXRST 0
`define SSR_C1_TXRST 1
`define SSR_C1_STRIP 2
`define SSR_C1_CLRSYN 3
`define SSR_C1_TIE 4
`define SSR_C1_RIE 5
`define SSR_C1_ACLO 6
// Control 2 fields.
`define SSR_C2_BYTE1 2
`define SSR_C2_WLSLO 3
`define SSR_C2_EIE 7
// Control 3 fields.
`define SSR_C3_EXT 0
`define SSR_C3_ONE 1
`define SSR_C3_CLRCTS 2
`define SSR_C3_CLRTUF 3
// Address-control codes for writes with select high.
`define SSR_AC_C2 2'h0
`define SSR_AC_C3 2'h1
`define SSR_AC_SYNC 2'h2
`define SSR_AC_TX 2'h3
// Status positions.
`define SSR_ST_DCD 2
`define SSR_ST_OVR 5
// Reset values.
`define SSR_C1_RST 8'h03
`define SSR_C2_RST 8'h00
`define SSR_C3_RST 2'h0
`define SSR_SYNC_RST 8'h00
`define SSR_SR_RST 9'h1FF
`endif

// file: ssr_pkg.sv
package ssr_pkg;
	typedef enum logic [1:0] {
		SSR_HUNT   = 2'b00,
		SSR_SECOND = 2'b01,
		SSR_SYNCED = 2'b10
	} ssr_sync_t;
endpackage : ssr_pkg

// file: ssr_line_model.sv
`timescale 1ns/1ps
module ssr_line_model
(
	output logic rx_clk, // Receive clock, still between frames.
	output logic rx_data // Serial data, least significant bit first.
);
	initial
	begin
		rx_clk = 1'b0;
		rx_data = 1'b1;
	end

	task automatic send(input logic [8:0] v, input int n);
		#7;
		for (int i = 0; i < n; i++)
		begin
			rx_data = v[i];
			#15 rx_clk = 1'b1;
			#15 rx_clk = 1'b0;
		end
		rx_data = ~rx_data;
	endtask : send
endmodule : ssr_line_model

// file: ssr_receiver_port_tb.sv
`timescale 1ns/1ps
module ssr_receiver_port_tb;
	logic       mclk;
	logic       rst_b;
	logic       e_pin;
	logic       cs_n;
	logic       reg_select;
	logic       rw;
	logic       carrier_detect_n;
	logic       tx_underflow;
	logic [7:0] d_in;
	logic [7:0] c1;
	logic [7:0] rd;
	wire  [7:0] d_out;
	wire  [7:0] tx_wr_data;
	wire        d_oe;
	wire        irq_oe;
	wire        tx_wr_stb;
	wire        tx_reset_bit;
	wire        rx_clk;
	wire        rx_data;
	int         errors;
	int         n_checks;
	int         stb_cnt;

	ssr_receiver_port uut
	(
		.mclk             (mclk),
		.rst_b            (rst_b),
		.e_pin            (e_pin),
		.cs_n             (cs_n),
		.reg_select       (reg_select),
		.rw               (rw),
		.d_in             (d_in),
		.d_out            (d_out),
		.d_oe             (d_oe),
		.irq_out          (),
		.irq_oe           (irq_oe),
		.carrier_detect_n (carrier_detect_n),
		.cts_n            (1'b0),
		.tx_underflow     (tx_underflow),
		.tx_fifo_free     (1'b1),
		.tx_wr_data       (tx_wr_data),
		.tx_wr_stb        (tx_wr_stb),
		.tx_reset_bit     (tx_reset_bit),
		.rx_clk           (rx_clk),
		.rx_data          (rx_data)
	);

	ssr_line_model line
	(
		.rx_clk  (rx_clk),
		.rx_data (rx_data)
	);

	always #25 mclk = ~mclk;

	always @(posedge mclk)
		if (tx_wr_stb === 1'b1)
			stb_cnt <= stb_cnt + 1;

	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic print_verdict;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic bus(input logic s, input logic r, input logic c, input logic [7:0] d);
		@(posedge mclk);
		#2;
		cs_n = c;
		reg_select = s;
		rw = r;
		d_in = d;
		repeat (3) @(posedge mclk);
		#2 e_pin = 1'b1;
		repeat (4) @(posedge mclk);
		#1 rd = d_out;
		chk({7'h0, d_oe}, {7'h0, r & ~c});
		#1 e_pin = 1'b0;
		repeat (4) @(posedge mclk);
		#1 chk({7'h0, d_oe}, 8'h00);
	endtask : bus

	task automatic rdc(input logic s, input logic [7:0] exp, input logic [7:0] m);
		bus(s, 1'b1, 1'b0, 8'h00);
		chk(rd & m, exp & m);
		if (!s)
			chk({7'h0, rd[7]}, {7'h0, irq_oe});
	endtask : rdc

	task automatic pulse(input int n);
		repeat (n) bus(1'b0, 1'b1, 1'b1, 8'h00);
	endtask : pulse

	task automatic w1(input logic [7:0] v);
		c1 = v;
		bus(1'b0, 1'b0, 1'b0, v);
	endtask : w1

	task automatic wx(input logic [1:0] ac, input logic [7:0] v);
		w1({ac, c1[5:0]});
		bus(1'b1, 1'b0, 1'b0, v);
	endtask : wx

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		mclk = 1'b0;
		rst_b = 1'b0;
		e_pin = 1'b0;
		cs_n = 1'b1;
		reg_select = 1'b0;
		rw = 1'b1;
		d_in = 8'h00;
		carrier_detect_n = 1'b0;
		tx_underflow = 1'b0;
		c1 = 8'h03;
		errors = 0;
		n_checks = 0;
		stb_cnt = 0;
		repeat (2) @(posedge mclk);
		#2 rst_b = 1'b1;
		chk({7'h0, tx_reset_bit}, 8'h01);
		rdc(1'b0, 8'h00, 8'hE5);
		line.send(9'h1FF, 4);
		wx(2'h2, 8'h16);
		wx(2'h0, 8'h9C);
		wx(2'h1, 8'h02);
		w1(8'h20);
		chk({7'h0, tx_reset_bit}, 8'h00);
		line.send(9'h007, 3);
		line.send(9'h016, 8);
		line.send(9'h0C3, 8);
		pulse(3);
		rdc(1'b0, 8'h81, 8'hE5);
		rdc(1'b1, 8'hC3, 8'hFF);
		pulse(3);
		rdc(1'b0, 8'h00, 8'hE5);
		line.send(9'h016, 8);
		pulse(3);
		rdc(1'b1, 8'h16, 8'hFF);
		w1(8'h24);
		line.send(9'h016, 8);
		line.send(9'h03C, 8);
		pulse(3);
		rdc(1'b1, 8'h3C, 8'hFF);
		pulse(3);
		rdc(1'b0, 8'h00, 8'h01);
		w1(8'h20);
		wx(2'h0, 8'h98);
		line.send(9'h041, 8);
		pulse(3);
		rdc(1'b0, 8'h00, 8'h01);
		line.send(9'h042, 8);
		pulse(3);
		rdc(1'b0, 8'h81, 8'h81);
		rdc(1'b1, 8'h41, 8'hFF);
		pulse(1);
		rdc(1'b1, 8'h42, 8'hFF);
		wx(2'h0, 8'h9C);
		line.send(9'h011, 8);
		line.send(9'h022, 8);
		pulse(3);
		rdc(1'b1, 8'h22, 8'hFF);
		rdc(1'b0, 8'hA0, 8'hE0);
		rdc(1'b1, 8'h22, 8'hFF);
		rdc(1'b0, 8'h00, 8'hE0);
		wx(2'h0, 8'hB4);
		line.send(9'h131, 9);
		pulse(3);
		rdc(1'b0, 8'h81, 8'hE1);
		rdc(1'b1, 8'h31, 8'hFF);
		line.send(9'h031, 9);
		pulse(3);
		rdc(1'b0, 8'hC1, 8'hE1);
		rdc(1'b1, 8'h31, 8'hFF);
		rdc(1'b0, 8'h00, 8'hE1);
		wx(2'h0, 8'h9C);
		w1(8'h28);
		line.send(9'h007, 3);
		line.send(9'h016, 8);
		line.send(9'h05E, 8);
		pulse(3);
		rdc(1'b0, 8'h00, 8'h01);
		wx(2'h1, 8'h00);
		w1(8'h20);
		line.send(9'h007, 3);
		line.send(9'h016, 8);
		line.send(9'h055, 8);
		line.send(9'h016, 8);
		line.send(9'h016, 8);
		line.send(9'h0A5, 8);
		pulse(3);
		rdc(1'b1, 8'hA5, 8'hFF);
		pulse(3);
		rdc(1'b0, 8'h00, 8'h01);
		wx(2'h0, 8'hDC);
		@(posedge mclk);
		#2 tx_underflow = 1'b1;
		repeat (3) @(posedge mclk);
		#2 tx_underflow = 1'b0;
		rdc(1'b0, 8'h10, 8'h10);
		wx(2'h1, 8'h08);
		rdc(1'b0, 8'h00, 8'h10);
		@(posedge mclk);
		#2 carrier_detect_n = 1'b1;
		rdc(1'b0, 8'h84, 8'h84);
		@(posedge mclk);
		#2 carrier_detect_n = 1'b0;
		rdc(1'b0, 8'h84, 8'h84);
		rdc(1'b1, 8'hA5, 8'hFF);
		rdc(1'b0, 8'h00, 8'h84);
		wx(2'h3, 8'hA7);
		chk(stb_cnt[7:0], 8'h01);
		chk(tx_wr_data, 8'hA7);
		print_verdict;
	end

	initial
	begin
		#2000000;
		errors++;
		$display("ERROR %0t run did not finish", $time);
		print_verdict;
	end
endmodule : ssr_receiver_port_tb
